// ===== sim/loop_vco_ctrl_regs_bench.sv
// self-checking bench for the loop and vco control bank
`timescale 1ns/1ps
`default_nettype none
`include "loop_ctrl_consts.vh"
module loop_vco_ctrl_regs_bench;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [9:0] reg_addr = 10'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic out_loop_locked = 1'b0;
  logic [7:0] reg_rdata, pump_current, d;
  logic reg_hit, zero_res_external, feedback_illegal, lock_det_pd, ref_doubler_en;
  logic dist_sync_hold, vco_midscale, vco_cal_run, vco_cal_start;
  logic [4:0] zero_res_sel;
  logic [8:0] feedback_ratio;
  logic [1:0] abl_width;
  logic [3:0] abl_onehot, pump_mode_onehot;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  int cal_starts = 0;
  logic [9:0] offs [5] = '{`OFF_ZERO_RES, `OFF_PUMP_CUR, `OFF_FB_DIV, `OFF_LOOP_CTL, `OFF_VCO_CTL};
  logic [7:0] rsts [5] = '{`RST_ZERO_RES, `RST_PUMP_CUR, `RST_FB_DIV, `RST_LOOP_CTL, `RST_VCO_CTL};
  logic [7:0] masks [5] = '{`MASK_ZERO_RES, 8'hff, 8'hff, `MASK_LOOP_CTL, `MASK_VCO_CTL};
  logic [7:0] fbs [6] = '{8'h03, 8'h44, 8'h84, 8'h85, 8'hc6, 8'h07};
  loop_vco_ctrl_regs u_dut (.*);
  // free-running clock
  initial begin
    forever #5 clock = ~clock;
  end
  task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  // write, then let register and output flop settle
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    @(negedge clock);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge clock);
    reg_wr = 1'b0;
    repeat (2) @(negedge clock);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] v, input logic h);
    @(negedge clock);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_rd = 1'b0;
    chk("read data", 9'(v), 9'(reg_rdata));
    chk("read hit", 9'(h), 9'(reg_hit));
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // count start pulses, since the pulse is gone before a write task returns
  always @(posedge clock) begin
    if (vco_cal_start === 1'b1) cal_starts++;
  end
  // cycle ceiling, the whole run needs about 150
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches++;
      end_of_test();
    end
  end
  // main sequence
  initial begin
    repeat (4) @(negedge clock);
    rst_b = 1'b1;
    for (int i = 0; i < 5; i++) rd(offs[i], rsts[i], 1'b1);
    chk("abl auto", 9'(`ABL_AUTO), 9'(abl_width));
    chk("sync hold", 9'h001, 9'(dist_sync_hold));
    for (int i = 0; i < 5; i++) wr(offs[i], 8'hff);
    for (int i = 0; i < 5; i++) rd(offs[i], masks[i], 1'b1);
    chk("pump", 9'h0ff, 9'(pump_current));
    chk("lock pd", 9'h001, 9'(lock_det_pd));
    chk("doubler", 9'h001, 9'(ref_doubler_en));
    chk("sync hold", 9'h000, 9'(dist_sync_hold));
    chk("midscale", 9'h001, 9'(vco_midscale));
    for (int m = 0; m < 4; m++) begin
      wr(`OFF_LOOP_CTL, 8'(8'h10 | m << 2 | m));
      chk("abl width", 9'(m), 9'(abl_width));
      chk("pump mode", 9'(1 << m), 9'(pump_mode_onehot));
      chk("lock pd", 9'h000, 9'(lock_det_pd));
    end
    wr(`OFF_LOOP_CTL, 8'h00);
    chk("abl auto", 9'(`ABL_AUTO), 9'(abl_width));
    chk("doubler", 9'h000, 9'(ref_doubler_en));
    for (int c = 0; c < 9; c++) begin
      wr(`OFF_ZERO_RES, 8'(c));
      chk("zero sel", c < 4 ? 9'(1 << c) : c < 8 ? 9'h010 : 9'h000, 9'(zero_res_sel));
      chk("zero ext", 9'(c == 8), 9'(zero_res_external));
    end
    foreach (fbs[i]) begin
      d = fbs[i];
      wr(`OFF_FB_DIV, d);
      chk("ratio", 9'(d[5:0]) * 4 + 9'(d[7:6]), feedback_ratio);
      chk("illegal", 9'(d[5:0] < 4 || d[5:0] < 7 && d[7:6] > (d[5:0] == 4 ? 1 : 2)),
          9'(feedback_illegal));
    end
    wr(`OFF_VCO_CTL, 8'h00);
    out_loop_locked = 1'b1;
    repeat (3) @(negedge clock);
    chk("sync hold", 9'h000, 9'(dist_sync_hold));
    out_loop_locked = 1'b0;
    wr(`OFF_VCO_CTL, 8'h02);
    chk("sync hold", 9'h001, 9'(dist_sync_hold));
    chk("cal starts", 9'h002, 9'(cal_starts));
    chk("cal start", 9'h000, 9'(vco_cal_start));
    @(negedge clock);
    chk("cal run", 9'h001, 9'(vco_cal_run & ~vco_cal_start));
    wr(`OFF_VCO_CTL, 8'h02);
    chk("cal starts", 9'h002, 9'(cal_starts));
    wr(10'h0f4, 8'hff);
    rd(10'h0f4, 8'h00, 1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire

// ===== sim/loop_vco_ctrl_regs_properties.sv
// port-level checks for the loop and vco control bank
`timescale 1ns/1ps
`default_nettype none
`include "loop_ctrl_consts.vh"
module loop_vco_ctrl_regs_properties (
  input wire clock,
  input wire rst_b,
  input wire reg_wr,
  input wire reg_rd,
  input wire [9:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire reg_hit,
  input wire out_loop_locked,
  input wire [4:0] zero_res_sel,
  input wire zero_res_external,
  input wire [7:0] pump_current,
  input wire [8:0] feedback_ratio,
  input wire feedback_illegal,
  input wire [1:0] abl_width,
  input wire [3:0] abl_onehot,
  input wire [3:0] pump_mode_onehot,
  input wire dist_sync_hold,
  input wire vco_cal_run,
  input wire vco_cal_start
);
  // ----------------------------------------
  // checks, all in the one clock domain
  // ----------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  property p_ctl_read;
    reg_rd && reg_addr == `OFF_LOOP_CTL |=> reg_hit && reg_rdata[6] == 1'b0;
  endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("control read bad");
  property p_vco_read;
    reg_rd && reg_addr == `OFF_VCO_CTL |=> (reg_rdata & ~`MASK_VCO_CTL) == 8'h00;
  endproperty
  a_vco_read: assert property (p_vco_read) else $error("vco reserved bits set");
  property p_unmapped;
    reg_rd && reg_addr == 10'h0f4 |=> !reg_hit && reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read bad");
  property p_pump;
    reg_wr && reg_addr == `OFF_PUMP_CUR ##1 !reg_wr |=> pump_current == $past(reg_wdata, 2);
  endproperty
  a_pump: assert property (p_pump) else $error("pump code not taken");
  property p_ratio;
    $past(rst_b) |-> feedback_illegal == (feedback_ratio inside {[0:15], 18, 19, 23, 27});
  endproperty
  a_ratio: assert property (p_ratio) else $error("illegal flag wrong");
  property p_abl;
    $past(rst_b) |-> abl_onehot == 4'h1 << abl_width;
  endproperty
  a_abl: assert property (p_abl) else $error("width decode wrong");
  property p_mode;
    $past(rst_b) |-> $onehot(pump_mode_onehot);
  endproperty
  a_mode: assert property (p_mode) else $error("pump mode not one-hot");
  property p_sync;
    out_loop_locked [*3] |-> !dist_sync_hold;
  endproperty
  a_sync: assert property (p_sync) else $error("sync held while locked");
  property p_cal;
    vco_cal_start |-> vco_cal_run && !$past(vco_cal_run) ##1 !vco_cal_start;
  endproperty
  a_cal: assert property (p_cal) else $error("cal start pulse bad");
  property p_zero;
    $onehot0({zero_res_external, zero_res_sel});
  endproperty
  a_zero: assert property (p_zero) else $error("resistor select bad");
endmodule
bind loop_vco_ctrl_regs loop_vco_ctrl_regs_properties u_props (.*);
`default_nettype wire

// ===== src/loop_ctrl_consts.vh
// register offsets, field positions, reset values for the loop and vco control bank
`ifndef LOOP_CTRL_CONSTS_VH
`define LOOP_CTRL_CONSTS_VH
`define ADDR_W 10
`define OFF_ZERO_RES 10'h01d
`define OFF_PUMP_CUR 10'h0f0
`define OFF_FB_DIV 10'h0f1
`define OFF_LOOP_CTL 10'h0f2
`define OFF_VCO_CTL 10'h0f3
`define RST_ZERO_RES 8'h00
`define RST_PUMP_CUR 8'h00
`define RST_FB_DIV 8'h00
`define RST_LOOP_CTL 8'h03
`define RST_VCO_CTL 8'h00
`define MASK_ZERO_RES 8'h0f
`define MASK_LOOP_CTL 8'hbf
`define MASK_VCO_CTL 8'h16
`define LC_LD_PD 7
`define LC_DOUBLER 5
`define LC_ABL_EN 4
`define LC_ABL_HI 3
`define LC_ABL_LO 2
`define LC_PUMP_HI 1
`define LC_PUMP_LO 0
`define VC_FORCE_REL 4
`define VC_MIDSCALE 2
`define VC_CAL 1
`define ABL_AUTO 2'h2
`define ZR_EXT 4'h8
`endif

// ===== src/loop_vco_ctrl_regs.v
// register bank and decoded controls for loop filter, pump, divider and vco
// Functional notes
// [RQ1] zero resistor code selects five values/external
// [RQ2] pump register is unsigned current magnitude
// [RQ3] feedback ratio is four B plus A
// [RQ4] software programs only legal A/B pairs
// [RQ5] bit 7 powers down lock detector
// [RQ6] software keeps control bit 6 zero
// [RQ7] bit 5 doubles reference frequency
// [RQ8] bit 4 low forces antibacklash high
// [RQ9] antibacklash field: min, low, high, max
// [RQ10] pump mode: tristate, up, down, normal
// [RQ11] hold distribution sync until loop locks
// [RQ12] force bit releases sync regardless
// [RQ13] software keeps vco bit 3 zero
// [RQ14] bit 2 forces vco midscale
// [RQ15] calibrate bit level, not self-clearing
// [RQ16] reserved bits ignore writes, read zero
`timescale 1ns/1ps
`default_nettype none
`include "loop_ctrl_consts.vh"
module loop_vco_ctrl_regs (
  input wire clock,
  input wire rst_b,
  input wire reg_wr,
  input wire reg_rd,
  input wire [9:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  output reg reg_hit,
  input wire out_loop_locked,
  output wire [4:0] zero_res_sel,
  output wire zero_res_external,
  output reg [7:0] pump_current,
  output reg [8:0] feedback_ratio,
  output reg feedback_illegal,
  output reg lock_det_pd,
  output reg ref_doubler_en,
  output reg [1:0] abl_width,
  output reg [3:0] abl_onehot,
  output reg [3:0] pump_mode_onehot,
  output reg dist_sync_hold,
  output reg vco_midscale,
  output reg vco_cal_run,
  output reg vco_cal_start
);
  // ---------------------------------------------
  // register storage
  // ---------------------------------------------
  reg [7:0] zero_res_q;
  reg [7:0] pump_cur_q;
  reg [7:0] fb_div_q;
  reg [7:0] loop_ctl_q;
  reg [7:0] vco_ctl_q;
  reg cal_prev_q;
  wire [5:0] b_count;
  wire [1:0] a_count;
  wire [1:0] abl_eff;

  // write decode; reserved bits are masked so they stay zero
  // [RQ16] mask reserved writes
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      zero_res_q <= `RST_ZERO_RES;
      pump_cur_q <= `RST_PUMP_CUR;
      fb_div_q <= `RST_FB_DIV;
      loop_ctl_q <= `RST_LOOP_CTL;
      vco_ctl_q <= `RST_VCO_CTL;
    end else if (reg_wr) begin
      case (reg_addr)
        `OFF_ZERO_RES: zero_res_q <= reg_wdata & `MASK_ZERO_RES;
        `OFF_PUMP_CUR: pump_cur_q <= reg_wdata;
        `OFF_FB_DIV: fb_div_q <= reg_wdata;
        // bit 6 must stay zero, so the mask keeps it there
        `OFF_LOOP_CTL: loop_ctl_q <= reg_wdata & `MASK_LOOP_CTL;
        `OFF_VCO_CTL: vco_ctl_q <= reg_wdata & `MASK_VCO_CTL;
        default: zero_res_q <= zero_res_q; // unmapped writes dropped
      endcase
    end
  end

  // ---------------------------------------------
  // read back
  // ---------------------------------------------
  // registered read data, zero for unmapped offsets
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
      reg_hit <= 1'b0;
    end else if (reg_rd) begin
      reg_hit <= 1'b1;
      case (reg_addr)
        `OFF_ZERO_RES: reg_rdata <= zero_res_q;
        `OFF_PUMP_CUR: reg_rdata <= pump_cur_q;
        `OFF_FB_DIV: reg_rdata <= fb_div_q;
        `OFF_LOOP_CTL: reg_rdata <= loop_ctl_q;
        `OFF_VCO_CTL: reg_rdata <= vco_ctl_q;
        default: begin
          reg_rdata <= 8'h00;
          reg_hit <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------
  // input-loop zero resistor
  // ---------------------------------------------
  // [RQ1] decode resistor code
  zero_res_decode u_zero_res (
    .code(zero_res_q[3:0]),
    .sel_onehot(zero_res_sel),
    .use_external(zero_res_external)
  );

  // ---------------------------------------------
  // output-loop controls, registered for clean outputs
  // ---------------------------------------------
  assign b_count = fb_div_q[5:0];
  assign a_count = fb_div_q[7:6];
  // [RQ8] auto antibacklash high
  assign abl_eff = loop_ctl_q[`LC_ABL_EN] ? loop_ctl_q[`LC_ABL_HI:`LC_ABL_LO] : `ABL_AUTO;

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pump_current <= 8'h00;
      feedback_ratio <= 9'h000;
      feedback_illegal <= 1'b0;
      lock_det_pd <= 1'b0;
      ref_doubler_en <= 1'b0;
      abl_width <= 2'h0;
      abl_onehot <= 4'h0;
      pump_mode_onehot <= 4'h0;
    end else begin
      // [RQ2] pump magnitude passthrough
      pump_current <= pump_cur_q;
      // [RQ3] ratio four B plus A
      feedback_ratio <= {1'b0, b_count, 2'b00} + {7'h00, a_count};
      // [RQ4] flag illegal A/B pair; flag only, the ratio is still used
      feedback_illegal <= (b_count < 6'd4) || ((b_count == 6'd4) && (a_count > 2'd1)) ||
                          ((b_count < 6'd7) && (a_count == 2'd3));
      // [RQ5] lock detector power-down
      lock_det_pd <= loop_ctl_q[`LC_LD_PD];
      // [RQ7] reference doubler enable
      ref_doubler_en <= loop_ctl_q[`LC_DOUBLER];
      abl_width <= abl_eff;
      // [RQ9] antibacklash width decode
      case (abl_eff)
        2'h0: abl_onehot <= 4'h1;
        2'h1: abl_onehot <= 4'h2;
        2'h2: abl_onehot <= 4'h4;
        default: abl_onehot <= 4'h8;
      endcase
      // [RQ10] pump mode decode
      case (loop_ctl_q[`LC_PUMP_HI:`LC_PUMP_LO])
        2'h0: pump_mode_onehot <= 4'h1; // tristate
        2'h1: pump_mode_onehot <= 4'h2; // constant up
        2'h2: pump_mode_onehot <= 4'h4; // constant down
        default: pump_mode_onehot <= 4'h8; // normal
      endcase
    end
  end

  // ---------------------------------------------
  // vco control
  // ---------------------------------------------
  // calibration start pulses on the 0 to 1 edge, so a rewrite of 1 does nothing
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dist_sync_hold <= 1'b1;
      vco_midscale <= 1'b0;
      vco_cal_run <= 1'b0;
      vco_cal_start <= 1'b0;
      cal_prev_q <= 1'b0;
    end else begin
      // [RQ11] hold until lock
      // [RQ12] force release ignores lock
      dist_sync_hold <= ~(vco_ctl_q[`VC_FORCE_REL] | out_loop_locked);
      // [RQ14] midscale force
      vco_midscale <= vco_ctl_q[`VC_MIDSCALE];
      // [RQ15] level calibrate, edge start
      vco_cal_run <= vco_ctl_q[`VC_CAL];
      cal_prev_q <= vco_ctl_q[`VC_CAL];
      vco_cal_start <= vco_ctl_q[`VC_CAL] & ~cal_prev_q;
    end
  end
endmodule
`default_nettype wire

// ===== src/zero_res_decode.v
// decoder of the input-loop zero resistor code into one-hot selects
`timescale 1ns/1ps
`default_nettype none
module zero_res_decode (
  input wire [3:0] code,
  output reg [4:0] sel_onehot,
  output reg use_external
);
  // -------------------------------------------------
  // decode: four descending values, then smallest
  // -------------------------------------------------
  // [RQ1] resistor code decode
  always @* begin
    sel_onehot = 5'h0_0;
    use_external = 1'b0;
    case (code)
      4'h0: sel_onehot = 5'h0_1;
      4'h1: sel_onehot = 5'h0_2;
      4'h2: sel_onehot = 5'h0_4;
      4'h3: sel_onehot = 5'h0_8;
      4'h4, 4'h5, 4'h6, 4'h7: sel_onehot = 5'h1_0;
      4'h8: use_external = 1'b1;
      default: sel_onehot = 5'h0_0; // unlisted codes select nothing
    endcase
  end
endmodule
`default_nettype wire
